// [rtl/aisf_consts.svh]
`ifndef AISF_CONSTS_SVH
`define AISF_CONSTS_SVH

// register byte offsets
`define AISF_OFF_CTRL   8'h00
`define AISF_OFF_POS    8'h04
`define AISF_OFF_FIRST_BUFFER_BASE  8'h08
`define AISF_OFF_SECOND_BUFFER_BASE  8'h0C
`define AISF_OFF_SIZE   8'h10
`define AISF_OFF_STAT   8'h14
`define AISF_OFF_MASK   8'h18
`define AISF_OFF_FRM    8'h1C

// control register fields
`define AISF_CTRL_EN    0
`define AISF_CTRL_LE    1
`define AISF_CTRL_SIGN  2
`define AISF_CTRL_FMT   3
`define AISF_CTRL_ORDER 5
`define AISF_CTRL_POL   6
`define AISF_CTRL_EDGE  7
`define AISF_CTRL_ACC   8

// position and frame register fields
`define AISF_POS_LEFT   0
`define AISF_POS_RIGHT  16
`define AISF_FRM_VALID  0
`define AISF_FRM_STOP   16

// status and mask bits
`define AISF_ST_FULL1   0
`define AISF_ST_FULL2   1
`define AISF_ST_OVR     2
`define AISF_ST_DROP    3
`define AISF_ST_ACT1    4

// reset values and alignment
`define AISF_RST_WORD   32'h0000_0000
`define AISF_RST_CTRL   10'h000
`define AISF_ALIGN_BITS 6

`endif

// [rtl/aisf_pkg.sv]
package aisf_pkg;

    // capture layout, in field encoding order
    typedef enum logic [1:0] {
        FMT_MONO8,
        FMT_STEREO8,
        FMT_MONO16,
        FMT_STEREO16
    } aisf_fmt_t;

    // memory writer states
    typedef enum logic [1:0] {
        WR_IDLE,
        WR_LEFT,
        WR_RIGHT
    } aisf_wr_state_t;

    // one sampled serial bit with its frame position
    typedef struct packed {
        logic       valid;
        logic [8:0] pos;
        logic       data;
    } aisf_bit_t;

    // one word write towards local memory
    typedef struct packed {
        logic        valid;
        logic [31:0] addr;
        logic [31:0] data;
        logic [3:0]  be;
    } aisf_mem_req_t;

endpackage

// [rtl/aisf_sync.sv]
`timescale 1ns/1ps
module aisf_sync #(
    parameter int W = 3
) (
    // clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // asynchronous levels in, synchronised levels out
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    // two flip-flops per bit, first stage read only by the second
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                meta_q[i] <= 1'b0;
                q[i]      <= 1'b0;
            end else begin
                meta_q[i] <= d[i];
                q[i]      <= meta_q[i];
            end
        end
    end

endmodule

// [rtl/aisf_chan.sv]
`timescale 1ns/1ps
module aisf_chan (
    // clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // serial bit stream
    input  wire aisf_pkg::aisf_bit_t bit_ev,
    input  wire logic              frame_start,
    // placement setup
    input  wire logic [8:0]        start_pos,
    input  wire logic [3:0]        stop_idx,
    input  wire logic              lsb_first,
    // assembled left-adjusted word
    output logic      [15:0]       word
);

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // distance from the first data bit and target bit index
    wire [8:0] rel      = bit_ev.pos - start_pos;
    wire       past_st  = bit_ev.pos >= start_pos;
    wire [8:0] span     = 9'(4'hF - stop_idx);
    wire       take     = bit_ev.valid && past_st && rel <= span;
    wire [3:0] idx_msb  = 4'hF - rel[3:0];
    wire [3:0] idx_lsb  = stop_idx + rel[3:0];
    wire [3:0] idx      = lsb_first ? idx_lsb : idx_msb;

    // bits below the stop index are never written, so they stay zero
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            word <= 16'h0000;
        end else if (frame_start) begin
            word <= 16'h0000;
        end else if (take) begin
            word[idx] <= bit_ev.data; // see RULE1 see RULE2
        end
    end

    msb_first_top_a: assert property ( // see RULE1
        take && !lsb_first && rel == 9'h000
        |=> word[15] == $past(bit_ev.data))
        else $error("first msb-first bit not in bit 15");

    lsb_first_stop_a: assert property ( // see RULE2
        take && lsb_first && rel == 9'h000
        |=> word[$past(stop_idx)] == $past(bit_ev.data))
        else $error("first lsb-first bit not at stop index");

    low_bits_zero_a: assert property ( // see RULE1
        $stable(stop_idx) && stop_idx == 4'h4 |-> word[3:0] == 4'h0)
        else $error("bits below stop index not zero");

endmodule

// [rtl/aisf_audio_in.sv]
// Overview of operation
// (RULE1) msb-first: start bit lands in bit 15
// (RULE2) lsb-first: start bit lands at stop index
// (RULE3) right word assembled alike from right start
// (RULE4) samples stored at increasing addresses
// (RULE5) byte order bit picks big or little
// (RULE6) two buffers, filled alternately
// (RULE7) 8-bit formats store upper byte only
// (RULE8) 16-bit formats store whole word
// (RULE9) sign convert inverts data msb
// (RULE10) mono/stereo byte and halfword memory layouts
// (RULE11) buffer bases 64-byte aligned, reset zero
// (RULE12) size counts samples per buffer, pairs once
// (RULE13) two-bit format field selects layout
// (RULE14) no a-law or mu-law companding
// (RULE15) position zero follows frame-start edge
// (RULE16) accept mode gates samples on valid bit
// (RULE17) full buffer flags, capture switches seamlessly
// (RULE18) position counter clears at frame start
//
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`include "aisf_consts.svh"
module aisf_audio_in #(
    parameter int CNT_W = 24
) (
    // bus clock and reset
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    // ahb-lite register slave
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    // converter serial pins
    input  wire logic                  serial_bit_clock,
    input  wire logic                  word_select_line,
    input  wire logic                  serial_data,
    // local memory write port
    output aisf_pkg::aisf_mem_req_t    mem_req,
    input  wire logic                  mem_ready,
    // interrupt level
    output logic                       irq
);

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // pin synchronisers
    logic [2:0] pins_s;
    aisf_sync #(.W(3)) u_sync (
        .hclk    (hclk),
        .hresetn (hresetn),
        .d       ({serial_bit_clock, word_select_line, serial_data}),
        .q       (pins_s)
    );
    wire sck_s = pins_s[2];
    wire ws_s  = pins_s[1];
    wire sd_s  = pins_s[0];

    // software visible state
    logic [9:0]       ctrl_q;
    logic [8:0]       left_start_position_q;
    logic [8:0]       right_start_position_q;
    logic [8:0]       valid_flag_position_q;
    logic [3:0]       stop_bit_index_q;
    logic [31:0]      first_buffer_base_q;
    logic [31:0]      second_buffer_base_q;
    logic [CNT_W-1:0] size_q;
    logic [3:0]       stat_q;
    logic [3:0]       mask_q;
    logic             first_active_q;

    // control fields
    wire cap_en        = ctrl_q[`AISF_CTRL_EN];
    wire little        = ctrl_q[`AISF_CTRL_LE];
    wire sign_conv     = ctrl_q[`AISF_CTRL_SIGN];
    wire bit_order_select = ctrl_q[`AISF_CTRL_ORDER];
    wire pol           = ctrl_q[`AISF_CTRL_POL];
    wire edge_sel      = ctrl_q[`AISF_CTRL_EDGE];
    wire [1:0] sample_accept_mode = ctrl_q[`AISF_CTRL_ACC +: 2];
    aisf_pkg::aisf_fmt_t capture_format;
    assign capture_format = aisf_pkg::aisf_fmt_t'(ctrl_q[`AISF_CTRL_FMT +: 2]);
    // format bit 0 is stereo, bit 1 is 16-bit
    wire stereo = capture_format == aisf_pkg::FMT_STEREO8 ||
                  capture_format == aisf_pkg::FMT_STEREO16; // see RULE13
    wire wide   = capture_format == aisf_pkg::FMT_MONO16 ||
                  capture_format == aisf_pkg::FMT_STEREO16; // see RULE13

    // serial edge and frame-start detection
    logic       sck_d_q;
    logic       ws_d_q;
    logic       in_frame_q;
    logic [8:0] bit_pos_q;
    wire samp     = edge_sel ? (sck_d_q & ~sck_s) : (~sck_d_q & sck_s);
    wire frame_st = samp && (ws_s != ws_d_q) && (ws_s == pol);
    aisf_pkg::aisf_bit_t bit_ev;
    assign bit_ev = {samp && in_frame_q && !frame_st, bit_pos_q, sd_s};

    // bit position counter, zero on the edge after frame start
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sck_d_q    <= 1'b0;
            ws_d_q     <= 1'b0;
            in_frame_q <= 1'b0;
            bit_pos_q  <= 9'h000;
        end else begin
            sck_d_q <= sck_s;
            if (samp) begin
                ws_d_q <= ws_s;
            end
            if (frame_st) begin
                in_frame_q <= 1'b1;
                bit_pos_q  <= 9'h000; // see RULE15 see RULE18
            end else if (bit_ev.valid && bit_pos_q != 9'h1FF) begin
                bit_pos_q <= bit_pos_q + 9'h001; // see RULE18
            end
        end
    end

    // valid bit capture for the accept modes
    logic valid_seen_q;
    logic valid_val_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            valid_seen_q <= 1'b0;
            valid_val_q  <= 1'b0;
        end else if (frame_st) begin
            valid_seen_q <= 1'b0;
        end else if (bit_ev.valid && bit_pos_q == valid_flag_position_q) begin
            valid_seen_q <= 1'b1;
            valid_val_q  <= sd_s;
        end
    end

    // a frame just ended; reserved mode accepts nothing
    wire acc_all   = sample_accept_mode == 2'h0;
    wire acc_flag  = sample_accept_mode[1] && valid_seen_q &&
                     valid_val_q == sample_accept_mode[0];
    wire accept    = in_frame_q && (acc_all || acc_flag); // see RULE16
    wire take_smp  = frame_st && accept && cap_en;

    // serial to parallel conversion per channel
    logic [15:0] left_word;
    logic [15:0] right_word;
    aisf_chan u_left (
        .hclk        (hclk),
        .hresetn     (hresetn),
        .bit_ev      (bit_ev),
        .frame_start (frame_st),
        .start_pos   (left_start_position_q),
        .stop_idx    (stop_bit_index_q),
        .lsb_first   (bit_order_select),
        .word        (left_word)
    );
    aisf_chan u_right ( // see RULE3
        .hclk        (hclk),
        .hresetn     (hresetn),
        .bit_ev      (bit_ev),
        .frame_start (frame_st),
        .start_pos   (right_start_position_q),
        .stop_idx    (stop_bit_index_q),
        .lsb_first   (bit_order_select),
        .word        (right_word)
    );

    // sample holding register with optional msb inversion
    aisf_pkg::aisf_wr_state_t wst_q;
    logic [15:0] left_q;
    logic [15:0] right_q;
    wire  [15:0] sign_mask = {sign_conv, 15'h0000};
    wire         idle      = wst_q == aisf_pkg::WR_IDLE;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            left_q  <= 16'h0000;
            right_q <= 16'h0000;
        end else if (take_smp && idle) begin
            left_q  <= left_word ^ sign_mask; // see RULE9
            right_q <= right_word ^ sign_mask; // see RULE9
        end
    end

    // element address and byte lanes
    logic [CNT_W-1:0] cnt_q;
    logic [31:0]      off_q;
    wire [31:0] base_cur = first_active_q ? first_buffer_base_q
                                          : second_buffer_base_q; // see RULE6
    wire [31:0] el_addr  = base_cur + off_q;
    wire [15:0] el_val   = (wst_q == aisf_pkg::WR_RIGHT) ? right_q : left_q;
    // raw upper byte, no companding table in the path
    wire [7:0]  el_byte  = el_val[15:8]; // see RULE7 see RULE14
    wire [1:0]  lane     = little ? el_addr[1:0]
                                  : 2'h3 - el_addr[1:0]; // see RULE5
    wire [3:0]  be8      = 4'h1 << lane;
    wire [3:0]  be16     = (little == el_addr[1]) ? 4'hC : 4'h3; // see RULE5
    assign mem_req = {!idle, el_addr[31:2], 2'h0,
                      wide ? {el_val, el_val} : {4{el_byte}}, // see RULE8
                      wide ? be16 : be8};

    // sample and buffer bookkeeping
    wire             mem_fire = mem_req.valid && mem_ready;
    wire             last_el  = !stereo || wst_q == aisf_pkg::WR_RIGHT;
    wire             smp_done = mem_fire && last_el;
    wire [CNT_W-1:0] cnt_nx   = cnt_q + CNT_W'(1);
    wire             buf_done = smp_done && cnt_nx >= size_q; // see RULE12
    wire [31:0]      step     = wide ? 32'h0000_0002 : 32'h0000_0001;

    // memory writer: left element, then right in stereo
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wst_q <= aisf_pkg::WR_IDLE;
        end else begin
            case (wst_q)
                aisf_pkg::WR_IDLE: begin
                    if (take_smp) begin
                        wst_q <= aisf_pkg::WR_LEFT;
                    end
                end
                aisf_pkg::WR_LEFT: begin
                    if (mem_ready) begin
                        wst_q <= stereo ? aisf_pkg::WR_RIGHT
                                        : aisf_pkg::WR_IDLE; // see RULE10
                    end
                end
                aisf_pkg::WR_RIGHT: begin
                    if (mem_ready) begin
                        wst_q <= aisf_pkg::WR_IDLE;
                    end
                end
                default: begin
                    wst_q <= aisf_pkg::WR_IDLE;
                end
            endcase
        end
    end

    // offset, sample count and active buffer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            off_q          <= `AISF_RST_WORD;
            cnt_q          <= '0;
            first_active_q <= 1'b1;
        end else if (buf_done) begin
            off_q          <= `AISF_RST_WORD;
            cnt_q          <= '0;
            first_active_q <= !first_active_q; // see RULE6 see RULE17
        end else if (mem_fire) begin
            off_q <= off_q + step; // see RULE4 see RULE10
            if (last_el) begin
                cnt_q <= cnt_nx; // see RULE12
            end
        end
    end

    // status events; a new event wins over a same-cycle clear
    wire       ovr_ev = buf_done && (first_active_q ? stat_q[`AISF_ST_FULL2]
                                                    : stat_q[`AISF_ST_FULL1]);
    wire [3:0] ev     = {take_smp && !idle, ovr_ev,
                         buf_done && !first_active_q,
                         buf_done && first_active_q}; // see RULE17

    // ahb-lite address phase capture
    logic        a_wr_q;
    logic [7:0]  a_addr_q;
    logic [31:0] rd_d;
    wire         addr_ph = hsel && htrans[1] && hready;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            a_wr_q   <= 1'b0;
            a_addr_q <= 8'h00;
        end else begin
            a_wr_q   <= addr_ph && hwrite;
            a_addr_q <= addr_ph ? haddr[7:0] : a_addr_q;
        end
    end

    // data phase write strobes
    wire wr_ctrl  = a_wr_q && a_addr_q == `AISF_OFF_CTRL;
    wire wr_pos   = a_wr_q && a_addr_q == `AISF_OFF_POS;
    wire wr_first_buffer_base = a_wr_q && a_addr_q == `AISF_OFF_FIRST_BUFFER_BASE;
    wire wr_second_buffer_base = a_wr_q && a_addr_q == `AISF_OFF_SECOND_BUFFER_BASE;
    wire wr_size  = a_wr_q && a_addr_q == `AISF_OFF_SIZE;
    wire wr_stat  = a_wr_q && a_addr_q == `AISF_OFF_STAT;
    wire wr_mask  = a_wr_q && a_addr_q == `AISF_OFF_MASK;
    wire wr_frm   = a_wr_q && a_addr_q == `AISF_OFF_FRM;
    wire [3:0] clr = wr_stat ? hwdata[3:0] : 4'h0;
    wire [31:0] base_in = {hwdata[31:`AISF_ALIGN_BITS],
                           `AISF_ALIGN_BITS'(0)}; // see RULE11

    // register writes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q                 <= `AISF_RST_CTRL;
            left_start_position_q  <= 9'h000;
            right_start_position_q <= 9'h000;
            valid_flag_position_q  <= 9'h000;
            stop_bit_index_q       <= 4'h0;
            first_buffer_base_q    <= `AISF_RST_WORD; // see RULE11
            second_buffer_base_q   <= `AISF_RST_WORD; // see RULE11
            size_q                 <= '0;
            mask_q                 <= 4'h0;
            stat_q                 <= 4'h0;
        end else begin
            if (wr_ctrl) ctrl_q <= hwdata[9:0];
            if (wr_pos) begin
                left_start_position_q  <= hwdata[`AISF_POS_LEFT +: 9];
                right_start_position_q <= hwdata[`AISF_POS_RIGHT +: 9];
            end
            if (wr_frm) begin
                valid_flag_position_q <= hwdata[`AISF_FRM_VALID +: 9];
                stop_bit_index_q      <= hwdata[`AISF_FRM_STOP +: 4];
            end
            if (wr_first_buffer_base) first_buffer_base_q <= base_in;
            if (wr_second_buffer_base) second_buffer_base_q <= base_in;
            if (wr_size) size_q <= hwdata[CNT_W-1:0];
            if (wr_mask) mask_q <= hwdata[3:0];
            stat_q <= (stat_q & ~clr) | ev;
        end
    end

    // read decode in the address phase
    always_comb begin
        rd_d = `AISF_RST_WORD;
        if (haddr[7:0] == `AISF_OFF_CTRL) begin
            rd_d = {22'h000000, ctrl_q};
        end else if (haddr[7:0] == `AISF_OFF_POS) begin
            rd_d = {7'h00, right_start_position_q,
                    7'h00, left_start_position_q};
        end else if (haddr[7:0] == `AISF_OFF_FIRST_BUFFER_BASE) begin
            rd_d = first_buffer_base_q;
        end else if (haddr[7:0] == `AISF_OFF_SECOND_BUFFER_BASE) begin
            rd_d = second_buffer_base_q;
        end else if (haddr[7:0] == `AISF_OFF_SIZE) begin
            rd_d = 32'(size_q);
        end else if (haddr[7:0] == `AISF_OFF_STAT) begin
            rd_d = {27'h0000000, first_active_q, stat_q};
        end else if (haddr[7:0] == `AISF_OFF_MASK) begin
            rd_d = {28'h0000000, mask_q};
        end else if (haddr[7:0] == `AISF_OFF_FRM) begin
            rd_d = {12'h000, stop_bit_index_q, 7'h00, valid_flag_position_q};
        end
    end

    // read data register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= `AISF_RST_WORD;
        end else if (addr_ph && !hwrite) begin
            hrdata <= rd_d;
        end
    end

    // zero wait state, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign irq       = |(stat_q & mask_q);

    // helper sequences for the writer
    sequence left_fire_s;
        wst_q == aisf_pkg::WR_LEFT && mem_ready;
    endsequence
    sequence right_next_s;
        wst_q == aisf_pkg::WR_RIGHT;
    endsequence

    // first sampled bit after a frame start is still pending
    logic first_due_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            first_due_q <= 1'b0;
        end else if (frame_st || bit_ev.valid) begin
            first_due_q <= frame_st;
        end
    end

    frame_pos_zero_a: assert property ( // see RULE18
        frame_st |=> bit_pos_q == 9'h000)
        else $error("bit position not cleared at frame start");

    first_bit_pos_a: assert property ( // see RULE15
        first_due_q && bit_ev.valid |-> bit_ev.pos == 9'h000)
        else $error("first bit after frame start not position zero");

    reserved_mode_a: assert property ( // see RULE16
        sample_accept_mode == 2'h1 |-> !accept)
        else $error("reserved accept mode took a sample");

    addr_rises_a: assert property ( // see RULE4
        mem_fire && !buf_done |=> off_q > $past(off_q))
        else $error("write offset did not increase");

    big_endian_byte_a: assert property ( // see RULE5
        mem_req.valid && !wide && !little && el_addr[1:0] == 2'h0
        |-> mem_req.be == 4'h8)
        else $error("big-endian byte in wrong lane");

    byte_format_a: assert property ( // see RULE7
        mem_req.valid && !wide |-> $onehot(mem_req.be) &&
        mem_req.data[31:24] == el_val[15:8])
        else $error("8-bit format not one upper byte");

    word_format_a: assert property ( // see RULE8
        mem_req.valid && wide |-> (mem_req.be == 4'hC ||
        mem_req.be == 4'h3) && mem_req.data[15:0] == el_val)
        else $error("16-bit format not a whole halfword");

    sign_invert_a: assert property ( // see RULE9
        take_smp && idle |=> left_q[15] == ($past(left_word[15]) ^
        $past(sign_conv)))
        else $error("msb inversion wrong");

    stereo_pair_a: assert property ( // see RULE10
        left_fire_s and stereo |=> right_next_s)
        else $error("stereo left not followed by right");

    buffer_swap_a: assert property ( // see RULE17
        buf_done && first_active_q
        |=> stat_q[`AISF_ST_FULL1] && !first_active_q && off_q == 32'h0)
        else $error("first buffer full did not swap");

    count_bound_a: assert property ( // see RULE12
        $stable(size_q) && size_q != '0 && cnt_q < size_q
        |=> cnt_q < size_q)
        else $error("sample count passed buffer size");

endmodule

// [test/aisf_adc_model.sv]
`timescale 1ns/1ps
module aisf_adc_model (
    // frame content
    input  wire logic [15:0] left_word,
    input  wire logic [15:0] right_word,
    // converter pins
    output logic             serial_bit_clock,
    output logic             word_select_line,
    output logic             serial_data
);
    logic [4:0]  cnt_q;
    logic [31:0] frm;
    assign frm = {left_word, right_word};
    // converter is timing master, its bit clock runs free
    initial begin
        serial_bit_clock = 1'b0;
        cnt_q = 5'h00;
        word_select_line = 1'b1;
        serial_data = 1'b0;
        forever #400 serial_bit_clock = ~serial_bit_clock;
    end
    // ws falls one bit ahead of position 0, data shifts on falling edge
    always @(negedge serial_bit_clock) begin
        word_select_line <= cnt_q[4];
        serial_data      <= frm[5'd31 - (cnt_q - 5'd1)];
        cnt_q            <= cnt_q + 5'd1;
    end
endmodule

// [test/tb.sv]
`timescale 1ns/1ps
`include "aisf_consts.svh"
module tb;
    logic                    hclk, hresetn, hsel, hwrite, hrdy, hresp, irq;
    logic                    sck, ws, sd, mem_ready;
    logic [1:0]              htrans;
    logic [2:0]              hsize;
    logic [31:0]             haddr, hwdata, hrdata, rd;
    logic [31:0]             q_a[$], q_d[$];
    logic [3:0]              q_b[$];
    logic [15:0]             lw = 16'hA5C3;
    logic [15:0]             rw = 16'h3C96;
    aisf_pkg::aisf_mem_req_t mem_req;
    int                      n_errors, num_checks;

    aisf_audio_in i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hresp(hresp),
        .hrdata(hrdata), .serial_bit_clock(sck), .word_select_line(ws),
        .serial_data(sd), .mem_req(mem_req), .mem_ready(mem_ready),
        .irq(irq));
    aisf_adc_model i_adc (.left_word(lw), .right_word(rw),
        .serial_bit_clock(sck), .word_select_line(ws), .serial_data(sd));

    // bus clock
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    // memory stalls every other cycle, logs accepted lanes only
    always @(posedge hclk) begin
        mem_ready <= ~mem_ready;
        if (mem_req.valid && mem_ready) begin
            q_a.push_back(mem_req.addr);
            q_b.push_back(mem_req.be);
            q_d.push_back(mem_req.data & {{8{mem_req.be[3]}},
                {8{mem_req.be[2]}}, {8{mem_req.be[1]}}, {8{mem_req.be[0]}}});
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one single ahb-lite transfer, read data lands in rd
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        htrans <= 2'h2;
        do @(posedge hclk); while (hrdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hrdy !== 1'b1);
        rd = hrdata;
    endtask
    task automatic do_reset();
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
    endtask
    // left-adjusted word as the receiving channel should assemble it
    function automatic logic [15:0] expw(input logic [15:0] v,
        input logic lsb, input logic [3:0] stop);
        logic [15:0] w;
        w = 16'h0000;
        for (int i = 0; i < 16; i++) begin
            if (i >= stop) w[i] = lsb ? v[15 - (i - stop)] : v[i];
        end
        return w;
    endfunction
    // capture four samples over both buffers and check every write
    task automatic run(input logic [1:0] fmt, input logic le, sg, lsb,
                       input logic [3:0] stop, input logic [1:0] acc);
        int          e, n, o;
        logic [15:0] v;
        logic [31:0] b;
        logic [3:0]  be;
        do_reset();
        bus(1'b1, `AISF_OFF_FIRST_BUFFER_BASE, 32'h0000_0147);
        bus(1'b1, `AISF_OFF_SECOND_BUFFER_BASE, 32'h0000_0200);
        bus(1'b1, `AISF_OFF_SIZE, 32'h0000_0002);
        bus(1'b1, `AISF_OFF_POS, 32'h0010_0000);
        bus(1'b1, `AISF_OFF_FRM, {12'h000, stop, 16'h0000});
        bus(1'b1, `AISF_OFF_MASK, 32'h0000_0001);
        // whole setup stands for a full frame before capture starts
        bus(1'b1, `AISF_OFF_CTRL, {22'h0, acc, 2'h0, lsb, fmt, sg, le, 1'b0});
        repeat (300) @(posedge hclk);
        q_a.delete();
        q_b.delete();
        q_d.delete();
        bus(1'b1, `AISF_OFF_CTRL, {22'h0, acc, 2'h0, lsb, fmt, sg, le, 1'b1});
        e = fmt[0] ? 2 : 1;
        for (int k = 0; k < 4 * e; k++) begin
            wait (q_a.size() > k);
            n = k / e;
            b = (n > 1) ? 32'h0000_0200 : 32'h0000_0140;
            o = ((n % 2) * e + k % e) * (fmt[1] ? 2 : 1);
            v = expw((k % e) ? rw : lw, lsb, stop);
            v[15] = v[15] ^ sg;
            if (!fmt[1]) be = 4'h1 << (le ? o % 4 : 3 - o % 4);
            else be = ((o % 4 == 0) ^ le) ? 4'hC : 4'h3;
            chk(q_a[k], (b + 32'(o)) & 32'hFFFF_FFFC);
            chk({28'h0, q_b[k]}, {28'h0, be});
            chk(q_d[k], (fmt[1] ? {2{v}} : {4{v[15:8]}}) & {{8{be[3]}},
                {8{be[2]}}, {8{be[1]}}, {8{be[0]}}});
        end
        chk({31'h0, irq}, 32'h1);
        bus(1'b1, `AISF_OFF_CTRL, 32'h0);
        repeat (20) @(posedge hclk);
        bus(1'b1, `AISF_OFF_STAT, 32'h0000_000F);
        @(posedge hclk);
        chk({31'h0, irq}, 32'h0);
        bus(1'b0, `AISF_OFF_FIRST_BUFFER_BASE, 32'h0);
        chk(rd, 32'h0000_0140);
        $display("capture run format %0d done", fmt);
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // watchdog, about six times the expected run length
    initial begin
        #5000000;
        n_errors++;
        $display("MISMATCH %0t watchdog expired", $time);
        stop_test();
    end
    initial begin
        {hresetn, hsel, hwrite, htrans, mem_ready} = 6'h00;
        {haddr, hwdata} = 64'h0;
        hsize = 3'h2;
        do_reset();
        bus(1'b0, `AISF_OFF_STAT, 32'h0);
        chk(rd, 32'h0000_0010);
        bus(1'b0, `AISF_OFF_CTRL, 32'h0);
        chk(rd, 32'h0);
        bus(1'b0, 8'h40, 32'h0);
        chk(rd, 32'h0);
        $display("reset value test done");
        run(2'h3, 1'b0, 1'b0, 1'b0, 4'h0, 2'h0);
        run(2'h2, 1'b1, 1'b1, 1'b0, 4'h0, 2'h0);
        run(2'h1, 1'b0, 1'b1, 1'b0, 4'h0, 2'h3);
        run(2'h0, 1'b1, 1'b0, 1'b1, 4'h4, 2'h0);
        run(2'h2, 1'b0, 1'b0, 1'b1, 4'h4, 2'h0);
        run(2'h3, 1'b1, 1'b0, 1'b0, 4'h4, 2'h0);
        // reserved accept mode stores nothing
        q_a.delete();
        bus(1'b1, `AISF_OFF_CTRL, 32'h0000_0101);
        repeat (600) @(posedge hclk);
        chk(32'(q_a.size()), 32'h0);
        $display("reserved accept mode test done");
        stop_test();
    end
endmodule
